// ==== rtl/dts_sequencer.v ====
// Dual time slot sequencer with register file, result registers and result FIFO
`default_nettype none
`include "dts_consts.vh"

module dts_sequencer #(
  parameter SAMPLE_TICK_CYC = `DTS_SAMPLE_TICK_CYC
) (
  input wire mclk_i,
  input wire rst_b_i,
  input wire [7:0] reg_addr_i,
  input wire [15:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  output reg [15:0] reg_rdata_o,
  input wire [19:0] adc_data_i,
  input wire adc_valid_i,
  output wire slot_a_active_o,
  output wire slot_b_active_o,
  output reg led_pulse_o,
  output reg [3:0] input_route_o,
  output reg [15:0] frontend_window_o,
  output wire [1:0] mode_o
);

  // ----------------------------------------
  // States
  // ----------------------------------------
  localparam [4:0] ST_IDLE = 5'h01, ST_A_PULSE = 5'h02, ST_A_PROC = 5'h04;
  localparam [4:0] ST_B_PULSE = 5'h08, ST_B_PROC = 5'h10;
  localparam [31:0] TICK_LAST = SAMPLE_TICK_CYC - 1, US_LAST = `DTS_US_CYC - 1;
  localparam [31:0] PROC_A = `DTS_PROC_A_US, PROC_B = `DTS_PROC_B_US, DEPTH = `DTS_FIFO_DEPTH;

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  reg [1:0] mode_q;
  reg [15:0] rate_q, route_q, a_led_q, a_cnt_q, b_led_q, b_cnt_q, a_win_q, b_win_q;
  reg [19:0] a_res_q, b_res_q, acc_q;
  reg [19:0] fifo_mem [0:`DTS_FIFO_DEPTH-1];
  reg [2:0] wr_ptr_q, rd_ptr_q;
  reg [3:0] fifo_cnt_q;
  reg [4:0] state_q;
  reg [12:0] tick_cnt_q;
  reg [15:0] period_cnt_q, phase_cnt_q;
  reg [7:0] us_cnt_q, pulse_left_q;

  wire sample_tick = (tick_cnt_q == TICK_LAST[12:0]);
  wire us_tick = (us_cnt_q == US_LAST[7:0]);
  wire normal = (mode_q == `DTS_MODE_NORMAL);
  wire fifo_pop = reg_rd_i && (reg_addr_i == `DTS_REG_FIFO_LO) && (fifo_cnt_q != 4'h0);
  wire [19:0] fifo_head = fifo_mem[rd_ptr_q];

  assign mode_o = mode_q;
  assign slot_a_active_o = (state_q == ST_A_PULSE);
  assign slot_b_active_o = (state_q == ST_B_PULSE);

  // Reserved route codes fall back to floating inputs
  function [3:0] route_code;
    input [3:0] sel;
    route_code = (sel == `DTS_ROUTE_SUMMED || sel == `DTS_ROUTE_SPLIT) ? sel : `DTS_ROUTE_FLOAT;
  endfunction

  always @(posedge mclk_i)
  begin
    if (!rst_b_i)
    begin
      mode_q <= `DTS_MODE_STANDBY;
      rate_q <= `DTS_RST_SAMPLE_RATE;
      route_q <= `DTS_RST_ROUTING;
      a_led_q <= `DTS_RST_LED_TIMING;
      a_cnt_q <= `DTS_RST_PULSE_COUNT;
      b_led_q <= `DTS_RST_LED_TIMING;
      b_cnt_q <= `DTS_RST_PULSE_COUNT;
      a_win_q <= `DTS_RST_FE_WINDOW;
      b_win_q <= `DTS_RST_FE_WINDOW;
    end
    else if (reg_wr_i)
    begin
      case (reg_addr_i)
        `DTS_REG_MODE: mode_q <= reg_wdata_i[1:0];
        `DTS_REG_SAMPLE_RATE: rate_q <= reg_wdata_i;
        `DTS_REG_ROUTING: route_q <= reg_wdata_i;
        `DTS_REG_A_LED_TIMING: a_led_q <= reg_wdata_i;
        `DTS_REG_A_PULSE_COUNT: a_cnt_q <= reg_wdata_i;
        `DTS_REG_B_LED_TIMING: b_led_q <= reg_wdata_i;
        `DTS_REG_B_PULSE_COUNT: b_cnt_q <= reg_wdata_i;
        `DTS_REG_A_FE_WINDOW: a_win_q <= reg_wdata_i;
        `DTS_REG_B_FE_WINDOW: b_win_q <= reg_wdata_i;
        default: mode_q <= mode_q;
      endcase
    end
  end

  always @(posedge mclk_i)
  begin
    if (!rst_b_i)
      reg_rdata_o <= 16'h0000;
    else if (reg_rd_i)
    begin
      case (reg_addr_i)
        `DTS_REG_STATUS: reg_rdata_o <= {6'h00, state_q, 1'b0, fifo_cnt_q};
        `DTS_REG_MODE: reg_rdata_o <= {14'h0000, mode_q};
        `DTS_REG_SAMPLE_RATE: reg_rdata_o <= rate_q;
        `DTS_REG_ROUTING: reg_rdata_o <= route_q;
        `DTS_REG_A_LED_TIMING: reg_rdata_o <= a_led_q;
        `DTS_REG_A_PULSE_COUNT: reg_rdata_o <= a_cnt_q;
        `DTS_REG_B_LED_TIMING: reg_rdata_o <= b_led_q;
        `DTS_REG_B_PULSE_COUNT: reg_rdata_o <= b_cnt_q;
        `DTS_REG_A_FE_WINDOW: reg_rdata_o <= a_win_q;
        `DTS_REG_B_FE_WINDOW: reg_rdata_o <= b_win_q;
        `DTS_REG_FIFO_LO: reg_rdata_o <= fifo_head[15:0];
        `DTS_REG_FIFO_HI: reg_rdata_o <= {12'h000, fifo_head[19:16]};
        `DTS_REG_A_RESULT_LO: reg_rdata_o <= a_res_q[15:0];
        `DTS_REG_A_RESULT_HI: reg_rdata_o <= {12'h000, a_res_q[19:16]};
        `DTS_REG_B_RESULT_LO: reg_rdata_o <= b_res_q[15:0];
        `DTS_REG_B_RESULT_HI: reg_rdata_o <= {12'h000, b_res_q[19:16]};
        default: reg_rdata_o <= 16'h0000;
      endcase
    end
  end

  // ----------------------------------------
  // 32 kHz sample clock and period timer
  // ----------------------------------------
  always @(posedge mclk_i)
  begin
    if (!rst_b_i)
    begin
      tick_cnt_q <= 13'h0000;
      period_cnt_q <= 16'h0000;
      us_cnt_q <= 8'h00;
    end
    else
    begin
      us_cnt_q <= us_tick ? 8'h00 : us_cnt_q + 8'h01;
      tick_cnt_q <= sample_tick ? 13'h0000 : tick_cnt_q + 13'h0001;
      if (!normal)
        period_cnt_q <= 16'h0000;
      else if (sample_tick)
      begin
        // Period counts sample-clock ticks; zero behaves as one
        period_cnt_q <= (period_cnt_q + 16'h0001 >= rate_q) ? 16'h0000
                        : period_cnt_q + 16'h0001;
      end
    end
  end

  wire period_start = normal && sample_tick && (period_cnt_q == 16'h0000);

  // ----------------------------------------
  // Slot sequencer
  // ----------------------------------------
  wire phase_done = us_tick && (phase_cnt_q <= 16'h0001);
  wire in_a = (state_q == ST_A_PULSE) || (state_q == ST_A_PROC);
  wire [7:0] cur_interval = in_a ? a_cnt_q[7:0] : b_cnt_q[7:0];
  // Leaving sampling mode during processing must not push a partial result
  wire fifo_push = normal && phase_done && ((state_q == ST_A_PROC) || (state_q == ST_B_PROC));

  always @(posedge mclk_i)
  begin
    if (!rst_b_i)
    begin
      state_q <= ST_IDLE;
      phase_cnt_q <= 16'h0000;
      pulse_left_q <= 8'h00;
      led_pulse_o <= 1'b0;
      acc_q <= 20'h00000;
      a_res_q <= 20'h00000;
      b_res_q <= 20'h00000;
    end
    else
    begin
      led_pulse_o <= 1'b0;
      if ((state_q == ST_A_PULSE || state_q == ST_B_PULSE) && adc_valid_i)
        acc_q <= acc_q + adc_data_i;
      if (us_tick && phase_cnt_q > 16'h0001)
        phase_cnt_q <= phase_cnt_q - 16'h0001;
      if (!normal)
        state_q <= ST_IDLE;
      else
        case (state_q)
          ST_IDLE:
            if (period_start)
            begin
              state_q <= ST_A_PULSE;
              phase_cnt_q <= {8'h00, a_led_q[7:0]};
              pulse_left_q <= a_cnt_q[15:8];
              acc_q <= 20'h00000;
            end
          ST_A_PULSE, ST_B_PULSE:
            if (phase_done)
            begin
              if (pulse_left_q != 8'h00)
              begin
                led_pulse_o <= 1'b1;
                pulse_left_q <= pulse_left_q - 8'h01;
                phase_cnt_q <= {8'h00, cur_interval};
              end
              else if (in_a)
              begin
                state_q <= ST_A_PROC;
                phase_cnt_q <= PROC_A[15:0];
              end
              else
              begin
                state_q <= ST_B_PROC;
                phase_cnt_q <= PROC_B[15:0];
              end
            end
          ST_A_PROC:
            if (phase_done)
            begin
              a_res_q <= acc_q;
              acc_q <= 20'h00000;
              state_q <= ST_B_PULSE;
              phase_cnt_q <= {8'h00, b_led_q[7:0]};
              pulse_left_q <= b_cnt_q[15:8];
            end
          ST_B_PROC:
            if (phase_done)
            begin
              b_res_q <= acc_q;
              state_q <= ST_IDLE;
            end
          default: state_q <= ST_IDLE;
        endcase
    end
  end

  // Route and window follow the slot in progress
  always @(posedge mclk_i)
  begin
    if (!rst_b_i || !(in_a || state_q == ST_B_PULSE || state_q == ST_B_PROC))
    begin
      input_route_o <= `DTS_ROUTE_FLOAT;
      frontend_window_o <= 16'h0000;
    end
    else if (in_a)
    begin
      input_route_o <= route_code(route_q[`DTS_ROUTE_A_MSB:`DTS_ROUTE_A_LSB]);
      frontend_window_o <= a_win_q;
    end
    else
    begin
      input_route_o <= route_code(route_q[`DTS_ROUTE_B_MSB:`DTS_ROUTE_B_LSB]);
      frontend_window_o <= b_win_q;
    end
  end

  // ----------------------------------------
  // Result FIFO
  // ----------------------------------------
  // A full FIFO drops the newest result; the result registers still update
  always @(posedge mclk_i)
  begin
    if (!rst_b_i)
    begin
      wr_ptr_q <= 3'h0;
      rd_ptr_q <= 3'h0;
      fifo_cnt_q <= 4'h0;
    end
    else
    begin
      if (fifo_push && (fifo_cnt_q != DEPTH[3:0] || fifo_pop))
      begin
        fifo_mem[wr_ptr_q] <= acc_q;
        wr_ptr_q <= wr_ptr_q + 3'h1;
      end
      if (fifo_pop)
        rd_ptr_q <= rd_ptr_q + 3'h1;
      if (fifo_push && (fifo_cnt_q != DEPTH[3:0]) && !fifo_pop)
        fifo_cnt_q <= fifo_cnt_q + 4'h1;
      else if (fifo_pop && !fifo_push)
        fifo_cnt_q <= fifo_cnt_q - 4'h1;
    end
  end

endmodule // dts_sequencer
`default_nettype wire

// ==== rtl/dts_consts.vh ====
// Register map and timing constants for the dual time slot sequencer
`ifndef DTS_CONSTS_VH
`define DTS_CONSTS_VH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define DTS_REG_STATUS 8'h00
`define DTS_REG_MODE 8'h10
`define DTS_REG_SAMPLE_RATE 8'h12
`define DTS_REG_ROUTING 8'h14
`define DTS_REG_A_LED_TIMING 8'h30
`define DTS_REG_A_PULSE_COUNT 8'h31
`define DTS_REG_B_LED_TIMING 8'h35
`define DTS_REG_B_PULSE_COUNT 8'h36
`define DTS_REG_A_FE_WINDOW 8'h39
`define DTS_REG_B_FE_WINDOW 8'h3B
`define DTS_REG_FIFO_LO 8'h60
`define DTS_REG_FIFO_HI 8'h61
`define DTS_REG_A_RESULT_LO 8'h64
`define DTS_REG_A_RESULT_HI 8'h65
`define DTS_REG_B_RESULT_LO 8'h66
`define DTS_REG_B_RESULT_HI 8'h67
// ----------------------------------------
// Field positions and codes
// ----------------------------------------
`define DTS_ROUTE_B_MSB 11
`define DTS_ROUTE_B_LSB 8
`define DTS_ROUTE_A_MSB 7
`define DTS_ROUTE_A_LSB 4
`define DTS_ROUTE_FLOAT 4'h0
`define DTS_ROUTE_SUMMED 4'h1
`define DTS_ROUTE_SPLIT 4'h5
`define DTS_MODE_STANDBY 2'h0
`define DTS_MODE_PROGRAM 2'h1
`define DTS_MODE_NORMAL 2'h2
// ----------------------------------------
// Reset values
// ----------------------------------------
`define DTS_RST_SAMPLE_RATE 16'h0008
`define DTS_RST_LED_TIMING 16'h0320
`define DTS_RST_PULSE_COUNT 16'h010F
`define DTS_RST_FE_WINDOW 16'h22F0
`define DTS_RST_ROUTING 16'h0110
// ----------------------------------------
// Timing
// ----------------------------------------
`define DTS_CLK_HZ 250000000
`define DTS_SAMPLE_CLK_HZ 32000
`define DTS_SAMPLE_TICK_CYC (`DTS_CLK_HZ / `DTS_SAMPLE_CLK_HZ)
`define DTS_US_CYC (`DTS_CLK_HZ / 1000000)
`define DTS_PROC_A_US 68
`define DTS_PROC_B_US 20
`define DTS_FIFO_DEPTH 8
`endif

// ==== test/dts_adc_model.sv ====
// Front-end model answering each light pulse with one conversion
`default_nettype none
module dts_adc_model (
  input wire logic mclk_i,
  input wire logic led_pulse_i,
  output logic adc_valid_o,
  output logic [19:0] adc_data_o
);
  timeunit 1ns;
  timeprecision 100ps;
  parameter logic [19:0] SAMPLE = 20'h01234;
  initial
  begin
    adc_valid_o = 1'b0;
    adc_data_o = 20'h00000;
  end
  // Data toggles when not valid so a stale sum cannot pass
  always @(posedge mclk_i)
  begin
    adc_valid_o <= #1 led_pulse_i;
    adc_data_o <= #1 led_pulse_i ? SAMPLE : ~adc_data_o;
  end
endmodule // dts_adc_model
`default_nettype wire

// ==== test/dts_seq_asserts.sv ====
// Port checker for the dual time slot sequencer
`default_nettype none
`include "dts_consts.vh"
module dts_seq_asserts (
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic reg_rd_i,
  input wire logic [15:0] reg_rdata_o,
  input wire logic slot_a_active_o,
  input wire logic slot_b_active_o,
  input wire logic led_pulse_o,
  input wire logic [3:0] input_route_o,
  input wire logic [1:0] mode_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // Tolerance covers the short first microsecond tick
  localparam int GAP_A_MIN = 16740;
  localparam int GAP_A_MAX = 17010;
  localparam int GAP_B_MIN = 4740;
  logic [15:0] gap_q;
  logic a_q;
  logic b_q;
  logic last_b_q;
  always_ff @(posedge mclk_i)
  begin
    if (!rst_b_i)
    begin
      gap_q <= 16'hFFFF;
      a_q <= 1'b0;
      b_q <= 1'b0;
      last_b_q <= 1'b1;
    end
    else
    begin
      a_q <= slot_a_active_o;
      b_q <= slot_b_active_o;
      if ((a_q && !slot_a_active_o) || (b_q && !slot_b_active_o))
        gap_q <= 16'h0000;
      else if (gap_q != 16'hFFFF)
        gap_q <= gap_q + 16'h0001;
      if (a_q && !slot_a_active_o)
        last_b_q <= 1'b0;
      else if (b_q && !slot_b_active_o)
        last_b_q <= 1'b1;
    end
  end
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_b_i);
  sequence s_quiet;
    !led_pulse_o [*8];
  endsequence
  a_slot_exclusive: assert property (!(slot_a_active_o && slot_b_active_o))
    else $error("both slots active");
  a_pulse_quiet: assert property (led_pulse_o |=> s_quiet)
    else $error("light pulse too long or too close");
  a_pulse_in_slot: assert property (led_pulse_o |->
    (slot_a_active_o || slot_b_active_o || $past(slot_a_active_o || slot_b_active_o)))
    else $error("light pulse outside a slot");
  a_proc_a_gap: assert property ($rose(slot_b_active_o) |->
    (gap_q >= GAP_A_MIN && gap_q <= GAP_A_MAX))
    else $error("slot A processing time wrong");
  a_proc_b_gap: assert property (($rose(slot_a_active_o) && last_b_q) |->
    gap_q >= GAP_B_MIN)
    else $error("slot B processing time too short");
  a_start_normal: assert property ($rose(slot_a_active_o) |-> mode_o == `DTS_MODE_NORMAL)
    else $error("slot started outside sampling mode");
  a_leave_idle: assert property ((mode_o != `DTS_MODE_NORMAL) |=>
    (!slot_a_active_o && !slot_b_active_o))
    else $error("slots active after leaving sampling mode");
  a_rdata_hold: assert property (!$past(reg_rd_i) |-> $stable(reg_rdata_o))
    else $error("read data changed without a read");
  a_route_legal: assert property (input_route_o == `DTS_ROUTE_FLOAT ||
    input_route_o == `DTS_ROUTE_SUMMED || input_route_o == `DTS_ROUTE_SPLIT)
    else $error("illegal route code");
endmodule // dts_seq_asserts
bind dts_sequencer dts_seq_asserts u_asserts (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
  .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .slot_a_active_o(slot_a_active_o),
  .slot_b_active_o(slot_b_active_o), .led_pulse_o(led_pulse_o),
  .input_route_o(input_route_o), .mode_o(mode_o));
`default_nettype wire

// ==== test/test_dual_time_slot_sequencer.sv ====
// Register-level testbench for the dual time slot sequencer
`default_nettype none
`include "dts_consts.vh"
module test_dual_time_slot_sequencer;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int TICK = 50;
  logic mclk_i, rst_b_i, reg_wr_i, reg_rd_i, adc_valid_i, slot_a, slot_b, led;
  logic [7:0] reg_addr_i;
  logic [15:0] reg_wdata_i, rdata, window;
  logic [19:0] adc_data_i;
  logic [3:0] route;
  logic [1:0] mode;
  int n_mismatch, tests_run, npulse, n;
  initial
  begin
    mclk_i = 1'b0;
    forever #2 mclk_i = ~mclk_i;
  end
  dts_sequencer #(.SAMPLE_TICK_CYC(TICK)) DUT (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(rdata), .adc_data_i(adc_data_i),
    .adc_valid_i(adc_valid_i), .slot_a_active_o(slot_a), .slot_b_active_o(slot_b),
    .led_pulse_o(led), .input_route_o(route), .frontend_window_o(window), .mode_o(mode));
  dts_adc_model u_adc (.mclk_i(mclk_i), .led_pulse_i(led), .adc_valid_o(adc_valid_i),
    .adc_data_o(adc_data_i));
  always @(posedge mclk_i)
    if (led === 1'b1)
      npulse++;
  task report_and_stop;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("ERROR %s expected %0h seen %0h", name, exp, got);
    end
  endtask
  task wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge mclk_i);
    #1;
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1'b1;
    @(posedge mclk_i);
    #1;
    reg_wr_i = 1'b0;
  endtask
  task rdchk(input string name, input logic [7:0] a, input logic [15:0] exp);
    @(posedge mclk_i);
    #1;
    reg_addr_i = a;
    reg_rd_i = 1'b1;
    @(posedge mclk_i);
    #1;
    reg_rd_i = 1'b0;
    chk(name, exp, rdata);
  endtask
  // Bounded wait for a slot level; n returns the cycles spent
  task wait_lvl(input logic sel_b, input logic lvl, input int lim);
    n = 0;
    while ((sel_b ? slot_b : slot_a) !== lvl)
    begin
      @(posedge mclk_i);
      #1;
      n++;
      if (n > lim)
      begin
        n_mismatch++;
        $display("ERROR slot wait expected %0d seen timeout", lvl);
        report_and_stop;
      end
    end
  endtask
  task settle;
    repeat (4) @(posedge mclk_i);
    #1;
  endtask
  initial
  begin
    rst_b_i = 1'b0;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    reg_addr_i = 8'h00;
    reg_wdata_i = 16'h0000;
    npulse = 0;
    repeat (3) @(posedge mclk_i);
    #1;
    rst_b_i = 1'b1;
    rdchk("rate", `DTS_REG_SAMPLE_RATE, `DTS_RST_SAMPLE_RATE);
    rdchk("routing", `DTS_REG_ROUTING, `DTS_RST_ROUTING);
    rdchk("b_window", `DTS_REG_B_FE_WINDOW, `DTS_RST_FE_WINDOW);
    rdchk("unmapped", 8'h20, 16'h0000);
    wr(`DTS_REG_MODE, 16'h0001);
    wr(`DTS_REG_A_LED_TIMING, 16'h0320);
    wr(`DTS_REG_B_LED_TIMING, 16'h0320);
    wr(`DTS_REG_A_PULSE_COUNT, 16'h0201);
    wr(`DTS_REG_SAMPLE_RATE, 16'hFFFF);
    rdchk("rate_w", `DTS_REG_SAMPLE_RATE, 16'hFFFF);
    wr(`DTS_REG_SAMPLE_RATE, 16'h0001);
    wr(`DTS_REG_ROUTING, 16'h0510);
    rdchk("b_count", `DTS_REG_B_PULSE_COUNT, `DTS_RST_PULSE_COUNT);
    wr(`DTS_REG_MODE, 16'h0002);
    wait_lvl(1'b0, 1'b1, 2 * TICK + 10);
    settle;
    chk("a_route", 16'h0001, {12'h000, route});
    chk("a_window", 16'h22F0, window);
    npulse = 0;
    wait_lvl(1'b0, 1'b0, 9000);
    chk("a_pulses", 16'h0002, npulse[15:0]);
    chk("a_time", 16'h0001, {15'h0000, n > 8200 && n < 8600});
    wait_lvl(1'b1, 1'b1, 17300);
    chk("a_proc", 16'h0001, {15'h0000, n > 16700 && n < 17100});
    settle;
    chk("b_route", 16'h0005, {12'h000, route});
    chk("b_win_out", 16'h22F0, window);
    npulse = 0;
    wait_lvl(1'b1, 1'b0, 12000);
    chk("b_pulses", 16'h0001, npulse[15:0]);
    chk("b_time", 16'h0001, {15'h0000, n > 11450 && n < 11850});
    // Past the B processing time, then stop before the next A result
    repeat (5100) @(posedge mclk_i);
    wr(`DTS_REG_MODE, 16'h0001);
    settle;
    chk("idle", 16'h0000, {14'h0000, slot_a, slot_b});
    chk("idle_route", 16'h0000, {12'h000, route});
    chk("idle_window", 16'h0000, window);
    rdchk("a_res_lo", `DTS_REG_A_RESULT_LO, 16'h2468);
    rdchk("a_res_hi", `DTS_REG_A_RESULT_HI, 16'h0000);
    rdchk("b_res_lo", `DTS_REG_B_RESULT_LO, 16'h1234);
    rdchk("b_res_hi", `DTS_REG_B_RESULT_HI, 16'h0000);
    rdchk("fifo_hi", `DTS_REG_FIFO_HI, 16'h0000);
    rdchk("fifo_a", `DTS_REG_FIFO_LO, 16'h2468);
    rdchk("fifo_b", `DTS_REG_FIFO_LO, 16'h1234);
    rdchk("status", `DTS_REG_STATUS, 16'h0020);
    wr(`DTS_REG_ROUTING, 16'h0030);
    wr(`DTS_REG_MODE, 16'h0002);
    wait_lvl(1'b0, 1'b1, 2 * TICK + 10);
    settle;
    chk("reserved", 16'h0000, {12'h000, route});
    wr(`DTS_REG_MODE, 16'h0000);
    settle;
    chk("abort", 16'h0000, {14'h0000, mode});
    chk("stopped", 16'h0000, {15'h0000, slot_a});
    report_and_stop;
  end
endmodule // test_dual_time_slot_sequencer
`default_nettype wire
